// File: pkg/pin_mux_pkg.sv
// Purpose: Constants for the multifunction pin configuration block
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   Bit fields are the same in both pin configuration registers
`default_nettype none
package pin_mux_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] BIDIR_CFG_IDX  = 6'h21;
  localparam logic [5:0] OUT_CFG_IDX    = 6'h22;
  localparam logic [5:0] LEVELS_IDX     = 6'h29;
  localparam logic [5:0] MONITOR_IDX    = 6'h2a;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         FUNC_LSB       = 4;
  localparam int         RSVD_BIT       = 3;
  localparam int         BIDIR_LVL_BIT  = 7;
  localparam int         OUT_LVL_BIT    = 6;
  localparam int         MON_BIT        = 7;
  localparam logic [7:0] BIDIR_CFG_RST  = 8'h22;
  localparam logic [7:0] OUT_CFG_RST    = 8'h00;
  localparam logic [7:0] LEVELS_RST     = 8'h00;
  localparam logic [7:0] LEVELS_MASK    = 8'hc0;
  localparam logic [7:0] CFG_MASK       = 8'hf7;
  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FN_DISABLED    = 4'h0;
  localparam logic [3:0] FN_GEN_OUT     = 4'h1;
  localparam logic [3:0] FN_IRQ_OUT     = 4'h2;
  localparam logic [3:0] FN_PDM_CLK     = 4'h4;
  localparam logic [3:0] FN_ADC_PD      = 4'h7;
  localparam logic [3:0] FN_MIC_BIAS    = 4'h8;
  localparam logic [3:0] FN_GEN_IN      = 4'h9;
  localparam logic [3:0] FN_MCLK_IN     = 4'ha;
  localparam logic [3:0] FN_SER_IN      = 4'hb;
  localparam logic [3:0] FN_PDM_A       = 4'hc;
  localparam logic [3:0] FN_PDM_B       = 4'hd;
  // ----------------------------------------------------------------
  // Drive styles
  // ----------------------------------------------------------------
  localparam logic [2:0] DRV_HIZ        = 3'h0;
  localparam logic [2:0] DRV_STRONG     = 3'h1;
  localparam logic [2:0] DRV_LOW_WEAKHI = 3'h2;
  localparam logic [2:0] DRV_LOW_ONLY   = 3'h3;
  localparam logic [2:0] DRV_WEAKLO_HI  = 3'h4;
  localparam logic [2:0] DRV_HIGH_ONLY  = 3'h5;
  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
endpackage
`default_nettype wire

// File: hdl/multifunction_pin_config.sv
// Purpose: Function select, drive style and output levels of two pins
// Assumes: Internal sources share aclk; the bidirectional pin is asynchronous
// Notes:   Pin outputs are registered, one cycle late; routed inputs pass a two-flop synchronizer, three cycles late
// How it works
// - Bidir function 0/1/2/4/7-13, reset two
// - Bidir codes 7, 8 and 10-13 route pin to inputs, 9 to monitor
// - Bidir drive style 0-5, reset two
// - Output pin function 0/1/2/4, reset zero
// - Output pin drive 0/1/3/5, others hi-z
// - Config bit three reads zero
// - Level register holds both levels, resets zero
// - Bit seven bidir, bit six output pin
// - Monitor bit seven shows sampled input
`timescale 1ns/100ps
`default_nettype none
module multifunction_pin_config
  import pin_mux_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Pins
  input  wire logic              bidir_pin_i,
  output logic                   bidir_pin_o,
  output logic                   bidir_pin_oe,
  output logic                   bidir_pin_weak,
  output logic                   output_only_pin_o,
  output logic                   output_only_pin_oe,
  output logic                   output_only_pin_weak,
  // Internal sources
  input  wire logic              irq_req,
  input  wire logic              pdm_clock_src,
  // Routed inputs
  output logic                   mic_bias_enable_in,
  output logic                   master_clock_in,
  output logic                   serial_audio_in,
  output logic                   pulse_density_data_in_a,
  output logic                   pulse_density_data_in_b,
  output logic                   adc_power_down
);
  // ----------------------------------------------------------------
  // Drive style to {oe, weak}; reserved styles leave the pin off
  // ----------------------------------------------------------------
  function automatic logic [1:0] drive(input logic [2:0] style, input logic lvl);
    logic [1:0] r;
    r = 2'b00;
    unique case (style)
      DRV_STRONG:     r = 2'b10;
      DRV_LOW_WEAKHI: r = lvl ? 2'b11 : 2'b10;
      DRV_LOW_ONLY:   r = lvl ? 2'b00 : 2'b10;
      DRV_WEAKLO_HI:  r = lvl ? 2'b10 : 2'b11;
      DRV_HIGH_ONLY:  r = lvl ? 2'b10 : 2'b00;
      default:        r = 2'b00;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [5:0]        aw_idx_q, aw_idx_d;
  logic [7:0]        w_byte_q, w_byte_d;
  logic              w_en_q, w_en_d;
  logic              awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]        bresp_d, rresp_d;
  logic [31:0]       rdata_d;
  logic [7:0]        bidir_cfg_q, bidir_cfg_d, out_cfg_q, out_cfg_d, levels_q, levels_d;
  logic              mon_q, mon_d, in_meta_q, in_sync_q;
  logic [2:0]        bpin_d, opin_d;
  logic [5:0]        route_d;
  logic              wr_fire, b_lvl, o_lvl;
  logic [1:0]        b_drv, o_drv;
  logic [5:0]        ar_idx;
  logic [3:0]        b_fn, o_fn;

  assign b_fn   = bidir_cfg_q[7:FUNC_LSB];
  assign o_fn   = out_cfg_q[7:FUNC_LSB];
  assign ar_idx = araddr[7:2];

  // ----------------------------------------------------------------
  // Bus slave and register file
  // ----------------------------------------------------------------
  always_comb begin
    aw_full_d   = aw_full_q;
    aw_idx_d    = aw_idx_q;
    w_full_d    = w_full_q;
    w_byte_d    = w_byte_q;
    w_en_d      = w_en_q;
    bvalid_d    = bvalid && !bready;
    bresp_d     = bresp;
    rvalid_d    = rvalid && !rready;
    rresp_d     = rresp;
    rdata_d     = rdata;
    bidir_cfg_d = bidir_cfg_q;
    out_cfg_d   = out_cfg_q;
    levels_d    = levels_q;
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
      aw_idx_d  = awaddr[7:2];
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
      w_byte_d = wdata[7:0];
      w_en_d   = wstrb[0];
    end
    wr_fire = aw_full_q && w_full_q && !bvalid;
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      unique case (aw_idx_q)
        BIDIR_CFG_IDX: if (w_en_q) bidir_cfg_d = w_byte_q & CFG_MASK;
        OUT_CFG_IDX:   if (w_en_q) out_cfg_d = w_byte_q & CFG_MASK;
        LEVELS_IDX:    if (w_en_q) levels_d = w_byte_q & LEVELS_MASK;
        MONITOR_IDX:   ;
        default:       bresp_d = RESP_SLVERR;
      endcase
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (ar_idx)
        BIDIR_CFG_IDX: rdata_d = {24'h000000, bidir_cfg_q};
        OUT_CFG_IDX:   rdata_d = {24'h000000, out_cfg_q};
        LEVELS_IDX:    rdata_d = {24'h000000, levels_q};
        MONITOR_IDX:   rdata_d = {24'h000000, mon_q, 7'h00};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_full_d;
    wready_d  = !w_full_d;
    arready_d = !rvalid_d;
  end

  // ----------------------------------------------------------------
  // Pin muxing
  // ----------------------------------------------------------------
  always_comb begin
    b_lvl = 1'b0;
    unique case (b_fn)
      FN_GEN_OUT: b_lvl = levels_q[BIDIR_LVL_BIT];
      FN_IRQ_OUT: b_lvl = irq_req;
      FN_PDM_CLK: b_lvl = pdm_clock_src;
      default:    b_lvl = 1'b0;
    endcase
    b_drv = drive(bidir_cfg_q[2:0], b_lvl);
    if (!(b_fn == FN_GEN_OUT || b_fn == FN_IRQ_OUT || b_fn == FN_PDM_CLK)) begin
      b_drv = 2'b00;
    end
    bpin_d = {b_lvl, b_drv};
    o_lvl = 1'b0;
    unique case (o_fn)
      FN_GEN_OUT: o_lvl = levels_q[OUT_LVL_BIT];
      FN_IRQ_OUT: o_lvl = irq_req;
      FN_PDM_CLK: o_lvl = pdm_clock_src;
      default:    o_lvl = 1'b0;
    endcase
    o_drv = 2'b00;
    if (out_cfg_q[2:0] == DRV_STRONG || out_cfg_q[2:0] == DRV_LOW_ONLY || out_cfg_q[2:0] == DRV_HIGH_ONLY) begin
      o_drv = drive(out_cfg_q[2:0], o_lvl);
    end
    if (!(o_fn == FN_GEN_OUT || o_fn == FN_IRQ_OUT || o_fn == FN_PDM_CLK)) begin
      o_drv = 2'b00;
    end
    opin_d = {o_lvl, o_drv};
    route_d = {b_fn == FN_MIC_BIAS, b_fn == FN_MCLK_IN, b_fn == FN_SER_IN,
               b_fn == FN_PDM_A, b_fn == FN_PDM_B, b_fn == FN_ADC_PD} & {6{in_sync_q}};
    mon_d = (b_fn == FN_GEN_IN) ? in_sync_q : mon_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q   <= 1'b0;
      aw_idx_q    <= 6'h00;
      w_full_q    <= 1'b0;
      w_byte_q    <= 8'h00;
      w_en_q      <= 1'b0;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
      arready     <= 1'b0;
      rvalid      <= 1'b0;
      rresp       <= RESP_OKAY;
      rdata       <= 32'h00000000;
      bidir_cfg_q <= BIDIR_CFG_RST;
      out_cfg_q   <= OUT_CFG_RST;
      levels_q    <= LEVELS_RST;
      mon_q       <= 1'b0;
      in_meta_q   <= 1'b0;
      in_sync_q   <= 1'b0;
      {bidir_pin_o, bidir_pin_oe, bidir_pin_weak} <= 3'h0;
      {output_only_pin_o, output_only_pin_oe, output_only_pin_weak} <= 3'h0;
      {mic_bias_enable_in, master_clock_in, serial_audio_in,
       pulse_density_data_in_a, pulse_density_data_in_b, adc_power_down} <= 6'h00;
    end else begin
      aw_full_q   <= aw_full_d;
      aw_idx_q    <= aw_idx_d;
      w_full_q    <= w_full_d;
      w_byte_q    <= w_byte_d;
      w_en_q      <= w_en_d;
      awready     <= awready_d;
      wready      <= wready_d;
      bvalid      <= bvalid_d;
      bresp       <= bresp_d;
      arready     <= arready_d;
      rvalid      <= rvalid_d;
      rresp       <= rresp_d;
      rdata       <= rdata_d;
      bidir_cfg_q <= bidir_cfg_d;
      out_cfg_q   <= out_cfg_d;
      levels_q    <= levels_d;
      mon_q       <= mon_d;
      in_meta_q   <= bidir_pin_i;
      in_sync_q   <= in_meta_q;
      {bidir_pin_o, bidir_pin_oe, bidir_pin_weak} <= bpin_d;
      {output_only_pin_o, output_only_pin_oe, output_only_pin_weak} <= opin_d;
      {mic_bias_enable_in, master_clock_in, serial_audio_in,
       pulse_density_data_in_a, pulse_density_data_in_b, adc_power_down} <= route_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_values: assert property ($rose(aresetn) |->
    bidir_cfg_q == 8'h22 && out_cfg_q == 8'h00 && levels_q == 8'h00)
    else $error("config reset values wrong");
  a_bit_three_zero: assert property (!bidir_cfg_q[3] && !out_cfg_q[3] && rdata[3] == 1'b0)
    else $error("bit three not zero");
  a_levels_reserved: assert property (levels_q[5:0] == 6'h00)
    else $error("level register reserved bits set");
  a_bidir_gen_out: assert property (b_fn == 4'h1 && bidir_cfg_q[2:0] == 3'h1 |=>
    bidir_pin_oe && bidir_pin_o == $past(levels_q[7]))
    else $error("bidir general output level wrong");
  a_bidir_irq: assert property (b_fn == 4'h2 && bidir_cfg_q[2:0] == 3'h1 |=>
    bidir_pin_oe && bidir_pin_o == $past(irq_req))
    else $error("interrupt not on bidir pin");
  a_bidir_weak_high: assert property (b_fn == 4'h1 && bidir_cfg_q[2:0] == 3'h2 && levels_q[7] |=>
    bidir_pin_oe && bidir_pin_weak)
    else $error("weak high style wrong");
  a_bidir_input_off: assert property (b_fn >= 4'h7 || b_fn == 4'h0 |=> !bidir_pin_oe)
    else $error("bidir driven in input function");
  a_input_route: assert property (b_fn == 4'hc |=> pulse_density_data_in_a == $past(in_sync_q)
    && !pulse_density_data_in_b)
    else $error("pdm data input not routed");
  a_out_reserved: assert property (out_cfg_q[2:0] inside {3'h2, 3'h4, 3'h6, 3'h7} |=> !output_only_pin_oe)
    else $error("output pin driven in reserved style");
  a_out_gen_out: assert property (o_fn == 4'h1 && out_cfg_q[2:0] == 3'h5 && levels_q[6] |=>
    output_only_pin_oe && output_only_pin_o)
    else $error("output pin high level wrong");
  a_monitor: assert property (b_fn == 4'h9 |=> mon_q == $past(in_sync_q))
    else $error("monitor bit not following input");

  c_write_cfg: cover property (wr_fire && aw_idx_q == 6'h21);
  c_read_monitor: cover property (arvalid && arready && ar_idx == 6'h2a);
  c_gen_out_high: cover property (output_only_pin_oe && output_only_pin_o);
  c_bidir_input: cover property (b_fn == 4'h9 ##1 mon_q);
endmodule  // multifunction_pin_config
`default_nettype wire

// File: dv/test_multifunction_pin_config.sv
// Purpose: Self-checking bench for the multifunction pin configuration block
// Assumes: AXI4-Lite byte address is four times the register index
// Notes:   Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/100ps
`default_nettype none
module test_multifunction_pin_config;
  import pin_mux_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        bidir_pin_i, bidir_pin_o, bidir_pin_oe, bidir_pin_weak;
  logic        output_only_pin_o, output_only_pin_oe, output_only_pin_weak;
  logic        irq_req, pdm_clock_src, mic_bias_enable_in, master_clock_in, serial_audio_in;
  logic        pulse_density_data_in_a, pulse_density_data_in_b, adc_power_down;
  int          failures, checked, cyc;
  multifunction_pin_config i_multifunction_pin_config (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .bidir_pin_i(bidir_pin_i),
    .bidir_pin_o(bidir_pin_o), .bidir_pin_oe(bidir_pin_oe), .bidir_pin_weak(bidir_pin_weak),
    .output_only_pin_o(output_only_pin_o), .output_only_pin_oe(output_only_pin_oe),
    .output_only_pin_weak(output_only_pin_weak), .irq_req(irq_req), .pdm_clock_src(pdm_clock_src),
    .mic_bias_enable_in(mic_bias_enable_in), .master_clock_in(master_clock_in),
    .serial_audio_in(serial_audio_in), .pulse_density_data_in_a(pulse_density_data_in_a),
    .pulse_density_data_in_b(pulse_density_data_in_b), .adc_power_down(adc_power_down));
  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      $display("Error at %0t: timeout", $time);
      failures++;
      final_report();
    end
  end
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr_x(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er, input logic [3:0] st);
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= st; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(bresp === er, "write response");
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_x(a, d, RESP_OKAY, 4'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata === {24'h0, e} && rresp === er, "read data or response");
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Expected {oe, weak} for a drive style and level; o marks the output-only pin
  function automatic logic [1:0] drv(input logic [2:0] s, input logic l, input logic o);
    case (s)
      3'h1:    drv = 2'b10;
      3'h2:    drv = o ? 2'b00 : {1'b1, l};
      3'h3:    drv = {~l, 1'b0};
      3'h4:    drv = o ? 2'b00 : {1'b1, ~l};
      3'h5:    drv = {l, 1'b0};
      default: drv = 2'b00;
    endcase
  endfunction
  task automatic pin(input logic o, oe, wk, input logic [1:0] e, input logic l, input string m);
    chk(oe === e[1] && (!e[1] || {o, wk} === {l, e[0]}), m);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_map();
    rd(8'h84, 8'h22, RESP_OKAY);
    rd(8'h88, 8'h00, RESP_OKAY);
    rd(8'ha4, 8'h00, RESP_OKAY);
    rd(8'hfc, 8'h00, RESP_SLVERR);
    wr(8'h88, 8'h11);
    rd(8'h88, 8'h11, RESP_OKAY);
    wr_x(8'h88, 8'h40, RESP_OKAY, 4'h0);
    rd(8'h88, 8'h11, RESP_OKAY);
    wr_x(8'hfc, 8'h55, RESP_SLVERR, 4'h1);
    wr(8'ha8, 8'h80);
    rd(8'ha8, 8'h00, RESP_OKAY);
    wr(8'ha4, 8'hff);
    rd(8'ha4, 8'hc0, RESP_OKAY);
  endtask
  task automatic t_drive_styles();
    logic l;
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 2; k++) begin
        l = k[0];
        wr(8'h84, {FN_GEN_OUT, 1'b0, s[2:0]});
        wr(8'h88, {FN_GEN_OUT, 1'b0, s[2:0]});
        wr(8'ha4, {l, ~l, 6'h00});
        repeat (2) @(posedge aclk);
        pin(bidir_pin_o, bidir_pin_oe, bidir_pin_weak, drv(s[2:0], l, 1'b0), l, "bidir drive");
        pin(output_only_pin_o, output_only_pin_oe, output_only_pin_weak, drv(s[2:0], ~l, 1'b1), ~l,
            "output pin drive");
      end
    end
  endtask
  task automatic t_irq_pdm();
    wr(8'h84, {FN_IRQ_OUT, 1'b0, DRV_STRONG});
    wr(8'h88, {FN_PDM_CLK, 1'b0, DRV_STRONG});
    for (int k = 0; k < 2; k++) begin
      irq_req <= k[0];
      pdm_clock_src <= ~k[0];
      repeat (3) @(posedge aclk);
      pin(bidir_pin_o, bidir_pin_oe, bidir_pin_weak, 2'b10, k[0], "irq routing");
      pin(output_only_pin_o, output_only_pin_oe, output_only_pin_weak, 2'b10, ~k[0], "pdm clock");
    end
    wr(8'h88, {4'h5, 1'b0, DRV_STRONG});
    repeat (2) @(posedge aclk);
    chk(output_only_pin_oe === 1'b0, "reserved function drives");
  endtask
  task automatic t_inputs();
    logic [5:0] e;
    for (int c = 6; c < 14; c++) begin
      case (c)
        7: e = 6'b100000; 8: e = 6'b010000; 10: e = 6'b001000;
        11: e = 6'b000100; 12: e = 6'b000010; 13: e = 6'b000001;
        default: e = 6'b000000;
      endcase
      wr(8'h84, {(c == 6) ? FN_DISABLED : c[3:0], 1'b0, DRV_STRONG});
      bidir_pin_i <= 1'b1;
      repeat (4) @(posedge aclk);
      chk({adc_power_down, mic_bias_enable_in, master_clock_in, serial_audio_in, pulse_density_data_in_a,
           pulse_density_data_in_b} === e, "input routing");
      chk(bidir_pin_oe === 1'b0, "input driver off");
      if (c == 9) rd(8'ha8, 8'h80, RESP_OKAY);
      bidir_pin_i <= 1'b0;
      repeat (4) @(posedge aclk);
      chk({adc_power_down, mic_bias_enable_in, master_clock_in, serial_audio_in, pulse_density_data_in_a,
           pulse_density_data_in_b} === 6'h00, "routing follows pin");
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0; bidir_pin_i = 1'b0;
    irq_req = 1'b0; pdm_clock_src = 1'b0; failures = 0; checked = 0; cyc = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_and_map();
    t_drive_styles();
    t_irq_pdm();
    t_inputs();
    final_report();
  end
endmodule // test_multifunction_pin_config
`default_nettype wire
